/* verilog/tmr_map.svh */
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH

// register offsets
`define TMR_REG_R2_HI 8'h04
`define TMR_REG_R2_LO 8'h05
`define TMR_REG_R3_HI 8'h06
`define TMR_REG_R3_LO 8'h07
`define TMR_REG_HOT_HI 8'h10
`define TMR_REG_HOT_LO 8'h11
`define TMR_REG_SEL 8'h12
`define TMR_REG_CTRL 8'h13
`define TMR_REG_IDEAL 8'h14
`define TMR_REG_REF_FIRST 8'h40
`define TMR_REG_REF_LAST 8'h47

// reset values
`define TMR_RST_TEMP 12'h000
`define TMR_RST_SEL 8'h0F
`define TMR_RST_CTRL 8'h10
`define TMR_RST_IDEAL 8'h18
`define TMR_RST_REF 8'h00
`define TMR_RST_BYTE 8'h00

// control bit positions
`define TMR_CTRL_STANDBY 7
`define TMR_CTRL_SOFT_RST 6
`define TMR_CTRL_TMO_DIS 5
`define TMR_CTRL_COMPARATOR 4
`define TMR_CTRL_FQ_HI 3
`define TMR_CTRL_FQ_LO 2
`define TMR_CTRL_WIDE 1
`define TMR_CTRL_SINGLE 0

// fault queue codes and depths
`define TMR_FQ_CODE_1 2'h0
`define TMR_FQ_CODE_2 2'h1
`define TMR_FQ_CODE_4 2'h2
`define TMR_FQ_DEPTH_1 3'h1
`define TMR_FQ_DEPTH_2 3'h2
`define TMR_FQ_DEPTH_4 3'h4
`define TMR_FQ_DEPTH_6 3'h6

// temperatures in sixteenths of a degree, 17-bit signed
`define TMR_MAX_NORM 17'h0_07FF
`define TMR_MAX_WIDE 17'h0_0BFF
`define TMR_MIN_TEMP 17'h1_F800

// bus framing and timing
`define TMR_BYTE_BITS 4'h8
`define TMR_FRAC_ZERO 4'h0
`define TMR_CLK_KHZ 32'h0000_61A8
`define TMR_TIMEOUT_MS 32'h0000_0019
`define TMR_TMO_BITS 20
`define TMR_SLAVE_ADDR 7'h1C

`endif

/* verilog/tmr_pkg.sv */
`include "tmr_map.svh"

package tmr_pkg;

	typedef enum logic [3:0] {
		TMR_BUS_IDLE,
		TMR_BUS_ADDR,
		TMR_BUS_ADDR_ACK,
		TMR_BUS_CMD,
		TMR_BUS_CMD_ACK,
		TMR_BUS_WDATA,
		TMR_BUS_WDATA_ACK,
		TMR_BUS_RDATA,
		TMR_BUS_RDATA_ACK
	} tmr_bus_e;

	// raw readings, sixteenths of a degree, signed, no custom offset
	typedef struct packed {
		logic [3:0][15:0] temp;
	} tmr_meas_s;

	typedef struct packed {
		logic [3:0] select;
		logic [3:0][11:0] refs;
		logic wide;
	} tmr_hot_cfg_s;

	typedef struct packed {
		tmr_bus_e bus;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic [7:0] tx;
		logic [7:0] ptr;
		logic rw;
		logic mack;
		logic sda_out;
		logic sda_oe_n;
		logic [1:0] scl_sync;
		logic [1:0] sda_sync;
		logic scl_prev;
		logic sda_prev;
		logic [`TMR_TMO_BITS-1:0] tmo;
		logic [11:0] r2;
		logic [11:0] r3;
		logic [11:0] hot;
		logic [7:0] sel;
		logic [7:0] ctrl;
		logic [7:0] ideal;
		logic [7:0][7:0] refs;
		logic [2:0] fault_cnt;
		logic run;
	} tmr_state_s;

	function automatic logic [16:0] tmr_clamp(input logic [16:0] v,
		input logic wide);
		logic signed [16:0] hi;
		hi = wide ? $signed(`TMR_MAX_WIDE) : $signed(`TMR_MAX_NORM);
		if ($signed(v) > hi) begin
			return hi;
		end
		if ($signed(v) < $signed(`TMR_MIN_TEMP)) begin
			return `TMR_MIN_TEMP;
		end
		return v;
	endfunction

endpackage

/* verilog/tmr_hottest.sv */
`timescale 1ns/1ns
`default_nettype none
`include "tmr_map.svh"

module tmr_hottest #(
	parameter int CHANNELS = 4
) (
	input wire tmr_pkg::tmr_meas_s meas,
	input wire tmr_pkg::tmr_hot_cfg_s cfg,
	output logic [11:0] hot,
	output logic hot_valid
);

	logic signed [16:0] best;
	logic signed [16:0] temp;
	logic signed [16:0] diff;
	logic [16:0] res;

	always_comb begin
		best = $signed(`TMR_MIN_TEMP);
		temp = '0;
		diff = '0;
		hot_valid = 1'b0;
		for (int i = 0; i < CHANNELS; i++) begin
			if (cfg.select[i]) begin
				temp = $signed(tmr_pkg::tmr_clamp({meas.temp[i][15],
					meas.temp[i]}, cfg.wide));
				// signed difference against the channel reference
				diff = temp - $signed({{5{cfg.refs[i][11]}},
					cfg.refs[i]});
				if (!hot_valid || diff > best) begin
					best = diff;
				end
				hot_valid = 1'b1;
			end
		end
		res = tmr_pkg::tmr_clamp(best, cfg.wide);
		hot = res[11:0];
	end

endmodule // tmr_hottest

`default_nettype wire

/* verilog/tmr_top.sv */
// Functional notes
// - hottest result is the largest of each selected reading minus its own reference
// - select bit 1 includes a channel, 0 excludes; all four after reset
// - upper four select bits come out of reset as zero
// - standby bit 7 stops the converter; 0 lets it run
// - writing 1 to bit 6 restores power-on state; bit reads 0
// - bit 5 at 0 enables the bus timeout, 1 disables it
// - bit 4: 0 interrupt style, 1 comparator style (reset value)
// - bits 3:2 pick fault depth 1, 2, 4 or 6 conversions
// - bit 1 clamps reported temperatures to 127.9375 or 191.9375
// - bit 0 starts one conversion round and clears when it ends
// - a write setting bit 0 ignores all other written bits
// - single round only accepted while in standby
// - control register holds 10h after reset
// - result upper bytes are read-only, sign then 64 down to 1
// - result lower bytes hold halves to sixteenths, low nibble zero
// - all result bytes read 00h after reset until a conversion
// - ideality code register, read/write, 18h after reset
// - per-channel reference bytes at 40h-47h, read/write, reset zero
// - hottest result uses raw readings, never the custom offset
`timescale 1ns/1ns
`default_nettype none
`include "tmr_map.svh"

module tmr_top #(
	parameter logic [6:0] SLAVE_ADDR = `TMR_SLAVE_ADDR,
	parameter int TIMEOUT_CYCLES = `TMR_CLK_KHZ * `TMR_TIMEOUT_MS
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic conv_done,
	input wire tmr_pkg::tmr_meas_s meas,
	output logic converter_run,
	output logic single_conv_req,
	output logic timeout_disable,
	output logic comparator_mode,
	output logic [2:0] fault_threshold,
	output logic wide_span_select,
	output logic [7:0] ideality_code
);

	localparam logic [`TMR_TMO_BITS-1:0] TMO_LAST =
		`TMR_TMO_BITS'(TIMEOUT_CYCLES - 1);

	tmr_pkg::tmr_state_s s;
	tmr_pkg::tmr_state_s n;
	tmr_pkg::tmr_hot_cfg_s hot_cfg;
	logic [11:0] hot_w;
	logic hot_valid;
	logic scl;
	logic sda;
	logic start;
	logic stop;
	logic rise;
	logic fall;
	logic [16:0] clamped2;
	logic [16:0] clamped3;

	function automatic logic [7:0] temp_hi(input logic [11:0] t);
		return t[11:4];
	endfunction

	function automatic logic [7:0] temp_lo(input logic [11:0] t);
		return {t[3:0], `TMR_FRAC_ZERO};
	endfunction

	function automatic logic [7:0] reg_read(input tmr_pkg::tmr_state_s st,
		input logic [7:0] a);
		logic [7:0] d;
		d = `TMR_RST_BYTE;
		case (a)
			`TMR_REG_R2_HI: d = temp_hi(st.r2);
			`TMR_REG_R2_LO: d = temp_lo(st.r2);
			`TMR_REG_R3_HI: d = temp_hi(st.r3);
			`TMR_REG_R3_LO: d = temp_lo(st.r3);
			`TMR_REG_HOT_HI: d = temp_hi(st.hot);
			`TMR_REG_HOT_LO: d = temp_lo(st.hot);
			`TMR_REG_SEL: d = st.sel;
			`TMR_REG_CTRL: d = st.ctrl;
			`TMR_REG_IDEAL: d = st.ideal;
			default: begin
				if (a >= `TMR_REG_REF_FIRST && a <= `TMR_REG_REF_LAST) begin
					d = st.refs[3'(a - `TMR_REG_REF_FIRST)];
				end
			end
		endcase
		return d;
	endfunction

	// register half of the state back to power-on values
	function automatic tmr_pkg::tmr_state_s reg_defaults(
		input tmr_pkg::tmr_state_s st);
		tmr_pkg::tmr_state_s r;
		r = st;
		r.r2 = `TMR_RST_TEMP;
		r.r3 = `TMR_RST_TEMP;
		r.hot = `TMR_RST_TEMP;
		r.sel = `TMR_RST_SEL;
		r.ctrl = `TMR_RST_CTRL;
		r.ideal = `TMR_RST_IDEAL;
		r.refs = {8{`TMR_RST_REF}};
		return r;
	endfunction

	function automatic tmr_pkg::tmr_state_s reg_write(
		input tmr_pkg::tmr_state_s st, input logic [7:0] a,
		input logic [7:0] d);
		tmr_pkg::tmr_state_s r;
		r = st;
		case (a)
			`TMR_REG_SEL: r.sel = d;
			`TMR_REG_IDEAL: r.ideal = d;
			`TMR_REG_CTRL: begin
				if (d[`TMR_CTRL_SINGLE]) begin
					if (st.ctrl[`TMR_CTRL_STANDBY]) begin
						r.ctrl[`TMR_CTRL_SINGLE] = 1'b1;
					end
				end else if (d[`TMR_CTRL_SOFT_RST]) begin
					r = reg_defaults(st);
				end else begin
					// a pending round survives a plain write
					r.ctrl = {d[7:1], st.ctrl[`TMR_CTRL_SINGLE]};
				end
			end
			default: begin
				if (a >= `TMR_REG_REF_FIRST && a <= `TMR_REG_REF_LAST) begin
					r.refs[3'(a - `TMR_REG_REF_FIRST)] = d;
				end
			end
		endcase
		return r;
	endfunction

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			hot_cfg.refs[i] = {s.refs[2 * i], s.refs[2 * i + 1][7:4]};
		end
		hot_cfg.select = s.sel[3:0];
		hot_cfg.wide = s.ctrl[`TMR_CTRL_WIDE];
	end

	// raw readings feed the max search, so any offset stays out of it
	tmr_hottest #(
		.CHANNELS(4)
	) u_hottest (
		.meas(meas),
		.cfg(hot_cfg),
		.hot(hot_w),
		.hot_valid(hot_valid)
	);

	always_comb begin
		n = s;
		n.scl_sync = {s.scl_sync[0], scl_in};
		n.sda_sync = {s.sda_sync[0], sda_in};
		n.scl_prev = s.scl_sync[1];
		n.sda_prev = s.sda_sync[1];
		scl = s.scl_sync[1];
		sda = s.sda_sync[1];
		start = scl && s.scl_prev && s.sda_prev && !sda;
		stop = scl && s.scl_prev && !s.sda_prev && sda;
		rise = scl && !s.scl_prev;
		fall = !scl && s.scl_prev;
		clamped2 = tmr_pkg::tmr_clamp({meas.temp[2][15], meas.temp[2]},
			s.ctrl[`TMR_CTRL_WIDE]);
		clamped3 = tmr_pkg::tmr_clamp({meas.temp[3][15], meas.temp[3]},
			s.ctrl[`TMR_CTRL_WIDE]);

		// round results first, so a same-cycle host write wins
		if (conv_done) begin
			n.r2 = clamped2[11:0];
			n.r3 = clamped3[11:0];
			if (hot_valid) begin
				n.hot = hot_w;
			end
			n.ctrl[`TMR_CTRL_SINGLE] = 1'b0;
		end

		// scl held low too long drops the transfer
		if (s.bus == tmr_pkg::TMR_BUS_IDLE || scl ||
			s.ctrl[`TMR_CTRL_TMO_DIS]) begin
			n.tmo = '0;
		end else begin
			n.tmo = s.tmo + 1'b1;
		end

		if (start) begin
			n.bus = tmr_pkg::TMR_BUS_ADDR;
			n.bit_cnt = '0;
			n.sda_oe_n = 1'b1;
		end else if (stop || s.tmo == TMO_LAST) begin
			n.bus = tmr_pkg::TMR_BUS_IDLE;
			n.sda_oe_n = 1'b1;
			n.tmo = '0;
		end else if (rise) begin
			case (s.bus)
				tmr_pkg::TMR_BUS_ADDR, tmr_pkg::TMR_BUS_CMD,
				tmr_pkg::TMR_BUS_WDATA: begin
					n.shift = {s.shift[6:0], sda};
					n.bit_cnt = s.bit_cnt + 1'b1;
				end
				tmr_pkg::TMR_BUS_RDATA: n.bit_cnt = s.bit_cnt + 1'b1;
				tmr_pkg::TMR_BUS_RDATA_ACK: n.mack = !sda;
				default: n.bit_cnt = s.bit_cnt;
			endcase
		end else if (fall) begin
			case (s.bus)
				tmr_pkg::TMR_BUS_ADDR: begin
					if (s.bit_cnt == `TMR_BYTE_BITS) begin
						if (s.shift[7:1] == SLAVE_ADDR) begin
							n.sda_oe_n = 1'b0;
							n.rw = s.shift[0];
							n.bus = tmr_pkg::TMR_BUS_ADDR_ACK;
						end else begin
							n.bus = tmr_pkg::TMR_BUS_IDLE;
						end
					end
				end
				tmr_pkg::TMR_BUS_ADDR_ACK: begin
					n.bit_cnt = '0;
					if (s.rw) begin
						n.tx = reg_read(s, s.ptr);
						n.sda_oe_n = n.tx[7];
						n.tx = {n.tx[6:0], 1'b0};
						n.bus = tmr_pkg::TMR_BUS_RDATA;
					end else begin
						n.sda_oe_n = 1'b1;
						n.bus = tmr_pkg::TMR_BUS_CMD;
					end
				end
				tmr_pkg::TMR_BUS_CMD: begin
					if (s.bit_cnt == `TMR_BYTE_BITS) begin
						n.ptr = s.shift;
						n.sda_oe_n = 1'b0;
						n.bus = tmr_pkg::TMR_BUS_CMD_ACK;
					end
				end
				tmr_pkg::TMR_BUS_CMD_ACK, tmr_pkg::TMR_BUS_WDATA_ACK: begin
					n.sda_oe_n = 1'b1;
					n.bit_cnt = '0;
					n.bus = tmr_pkg::TMR_BUS_WDATA;
				end
				tmr_pkg::TMR_BUS_WDATA: begin
					if (s.bit_cnt == `TMR_BYTE_BITS) begin
						n = reg_write(n, s.ptr, s.shift);
						n.sda_oe_n = 1'b0;
						n.bus = tmr_pkg::TMR_BUS_WDATA_ACK;
					end
				end
				tmr_pkg::TMR_BUS_RDATA: begin
					if (s.bit_cnt == `TMR_BYTE_BITS) begin
						n.sda_oe_n = 1'b1;
						n.bus = tmr_pkg::TMR_BUS_RDATA_ACK;
					end else begin
						n.sda_oe_n = s.tx[7];
						n.tx = {s.tx[6:0], 1'b0};
					end
				end
				tmr_pkg::TMR_BUS_RDATA_ACK: begin
					n.bit_cnt = '0;
					if (s.mack) begin
						// repeat reads stay on the same pointer
						n.tx = reg_read(s, s.ptr);
						n.sda_oe_n = n.tx[7];
						n.tx = {n.tx[6:0], 1'b0};
						n.bus = tmr_pkg::TMR_BUS_RDATA;
					end else begin
						n.bus = tmr_pkg::TMR_BUS_IDLE;
					end
				end
				default: n.sda_oe_n = 1'b1;
			endcase
		end

		// outputs as flops, taken from the next control value
		n.run = !n.ctrl[`TMR_CTRL_STANDBY];
		case (n.ctrl[`TMR_CTRL_FQ_HI:`TMR_CTRL_FQ_LO])
			`TMR_FQ_CODE_1: n.fault_cnt = `TMR_FQ_DEPTH_1;
			`TMR_FQ_CODE_2: n.fault_cnt = `TMR_FQ_DEPTH_2;
			`TMR_FQ_CODE_4: n.fault_cnt = `TMR_FQ_DEPTH_4;
			default: n.fault_cnt = `TMR_FQ_DEPTH_6;
		endcase
		n.sda_out = 1'b0;

		if (srst) begin
			n = reg_defaults(n);
			n.bus = tmr_pkg::TMR_BUS_IDLE;
			n.bit_cnt = '0;
			n.shift = '0;
			n.tx = '0;
			n.ptr = '0;
			n.rw = 1'b0;
			n.mack = 1'b0;
			n.sda_oe_n = 1'b1;
			n.scl_sync = 2'h3;
			n.sda_sync = 2'h3;
			n.scl_prev = 1'b1;
			n.sda_prev = 1'b1;
			n.tmo = '0;
			n.run = 1'b1;
			n.fault_cnt = `TMR_FQ_DEPTH_1;
		end
	end

	always_ff @(posedge clk) begin
		s <= n;
	end

	assign sda_out = s.sda_out;
	assign sda_oe_n = s.sda_oe_n;
	assign converter_run = s.run;
	assign single_conv_req = s.ctrl[`TMR_CTRL_SINGLE];
	assign timeout_disable = s.ctrl[`TMR_CTRL_TMO_DIS];
	assign comparator_mode = s.ctrl[`TMR_CTRL_COMPARATOR];
	assign fault_threshold = s.fault_cnt;
	assign wide_span_select = s.ctrl[`TMR_CTRL_WIDE];
	assign ideality_code = s.ideal;

endmodule // tmr_top

`default_nettype wire

/* tb/tmr_top_props.sv */
`timescale 1ns/1ns
`default_nettype none
module tmr_top_props (
	input wire logic clk,
	input wire logic srst,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic conv_done,
	input wire logic converter_run,
	input wire logic single_conv_req,
	input wire logic timeout_disable,
	input wire logic comparator_mode,
	input wire logic [2:0] fault_threshold,
	input wire logic wide_span_select,
	input wire logic [7:0] ideality_code
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// six high cycles outlast the two-stage synchroniser
	sequence scl_quiet;
		scl_in [*6];
	endsequence
	rst_values_a: assert property (
		$fell(srst) |-> converter_run && comparator_mode && !single_conv_req
		&& fault_threshold == 3'h1 && !wide_span_select && !timeout_disable
		&& ideality_code == 8'h18 && sda_oe_n)
		else $error("control outputs wrong after reset");
	fq_legal_a: assert property (
		fault_threshold inside {3'h1, 3'h2, 3'h4, 3'h6})
		else $error("fault depth outside 1 2 4 6");
	single_clear_a: assert property (
		single_conv_req && conv_done |=> !single_conv_req)
		else $error("single round not cleared");
	single_standby_a: assert property (
		$rose(single_conv_req) |-> !converter_run && !$past(converter_run))
		else $error("single round outside standby");
	single_alone_a: assert property (
		$rose(single_conv_req) |-> $stable(fault_threshold)
		&& $stable(comparator_mode) && $stable(wide_span_select)
		&& $stable(timeout_disable))
		else $error("single round write changed other bits");
	cfg_quiet_a: assert property (
		scl_quiet |-> $stable({ideality_code, fault_threshold, converter_run,
		comparator_mode, wide_span_select, timeout_disable}))
		else $error("control changed without bus activity");
	ack_scl_low_a: assert property (
		$fell(sda_oe_n) |-> !scl_in)
		else $error("data line pulled while clock high");
	sda_drain_a: assert property (sda_out == 1'b0)
		else $error("data output not open drain");
endmodule // tmr_top_props
bind tmr_top tmr_top_props i_props (.clk(clk), .srst(srst),
	.scl_in(scl_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
	.conv_done(conv_done), .converter_run(converter_run),
	.single_conv_req(single_conv_req), .timeout_disable(timeout_disable),
	.comparator_mode(comparator_mode), .fault_threshold(fault_threshold),
	.wide_span_select(wide_span_select), .ideality_code(ideality_code));
`default_nettype wire

/* tb/tmr_host.sv */
`timescale 1ns/1ns
`default_nettype none
`include "tmr_map.svh"
module tmr_host (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_drv,
	output logic nak
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
		nak = 1'b0;
	end
	// 16 clocks a bit keeps both clock phases past the synchroniser
	task automatic w(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic put(input logic b);
		sda_drv <= b;
		w(4);
		scl <= 1'b1;
		w(8);
		scl <= 1'b0;
		w(4);
	endtask
	task automatic get(output logic b);
		sda_drv <= 1'b1;
		w(4);
		scl <= 1'b1;
		w(4);
		b = sda;
		w(4);
		scl <= 1'b0;
		w(4);
	endtask
	task automatic tx(input logic [7:0] d);
		logic a;
		for (int i = 7; i >= 0; i--) put(d[i]);
		get(a);
		nak = nak | a;
	endtask
	task automatic start();
		sda_drv <= 1'b1;
		w(4);
		scl <= 1'b1;
		w(8);
		sda_drv <= 1'b0;
		w(8);
		scl <= 1'b0;
		w(4);
	endtask
	task automatic stop();
		sda_drv <= 1'b0;
		w(4);
		scl <= 1'b1;
		w(8);
		sda_drv <= 1'b1;
		w(8);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		start();
		tx({`TMR_SLAVE_ADDR, 1'b0});
		tx(a);
		tx(d);
		stop();
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		start();
		tx({`TMR_SLAVE_ADDR, 1'b0});
		tx(a);
		start();
		tx({`TMR_SLAVE_ADDR, 1'b1});
		for (int i = 7; i >= 0; i--) get(d[i]);
		put(1'b1);
		stop();
	endtask
endmodule // tmr_host
`default_nettype wire

/* tb/test_tmr_top.sv */
`timescale 1ns/1ns
`default_nettype none
module test_tmr_top;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic conv_done = 1'b0;
	tmr_pkg::tmr_meas_s meas = '0;
	logic scl, host_sda, nak, sda_out, sda_oe_n, run, single, tmo, cmp, wide;
	logic [2:0] fq;
	logic [7:0] ideal, rv;
	int error_cnt = 0;
	int samples_checked = 0;
	// pull-up: a released line reads high
	wire sda = host_sda & (sda_oe_n | sda_out);
	wire [7:0] outs = {run, single, tmo, cmp, fq, wide};
	// short timeout keeps a stalled bus cheap to reach
	tmr_top #(.TIMEOUT_CYCLES(200)) i_dut (.clk(clk), .srst(srst),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.conv_done(conv_done), .meas(meas), .converter_run(run),
		.single_conv_req(single), .timeout_disable(tmo),
		.comparator_mode(cmp), .fault_threshold(fq),
		.wide_span_select(wide), .ideality_code(ideal));
	tmr_host i_host (.clk(clk), .sda(sda), .scl(scl), .sda_drv(host_sda),
		.nak(nak));
	initial begin
		forever #20 clk = ~clk;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		i_host.rd(a, rv);
		chk(rv, exp);
	endtask
	task automatic conv(input logic [63:0] t);
		meas <= t;
		@(posedge clk);
		conv_done <= 1'b1;
		@(posedge clk);
		conv_done <= 1'b0;
	endtask
	task automatic t_reset();
		for (int a = 4; a < 8; a++) rchk(8'(a), 8'h00);
		rchk(8'h10, 8'h00);
		rchk(8'h11, 8'h00);
		rchk(8'h12, 8'h0F);
		rchk(8'h13, 8'h10);
		rchk(8'h14, 8'h18);
		for (int a = 64; a < 72; a++) rchk(8'(a), 8'h00);
		chk(outs, 8'h92);
		chk(ideal, 8'h18);
	endtask
	task automatic t_ctrl();
		logic [2:0] depth [4] = '{3'h1, 3'h2, 3'h4, 3'h6};
		for (int k = 0; k < 4; k++) begin
			i_host.wr(8'h13, 8'h22 | 8'(k << 2));
			chk(outs, {4'hA, depth[k], 1'b1});
			rchk(8'h13, 8'h22 | 8'(k << 2));
		end
		i_host.wr(8'h13, 8'h80);
		chk(outs, 8'h02);
		i_host.wr(8'h13, 8'h3D);
		chk(outs, 8'h42);
		rchk(8'h13, 8'h81);
		conv('0);
		@(posedge clk);
		chk(outs, 8'h02);
		i_host.wr(8'h13, 8'h00);
		i_host.wr(8'h13, 8'h01);
		chk(outs, 8'h82);
		rchk(8'h13, 8'h00);
	endtask
	task automatic t_hot();
		logic [63:0] m = {16'hFFE0, 16'h0180, 16'h00A0, 16'h0145};
		i_host.wr(8'h44, 8'h05);
		rchk(8'h44, 8'h05);
		conv(m);
		rchk(8'h10, 8'h14);
		rchk(8'h11, 8'h50);
		rchk(8'h04, 8'h18);
		rchk(8'h06, 8'hFE);
		i_host.wr(8'h12, 8'h04);
		conv(m);
		rchk(8'h10, 8'h13);
		i_host.wr(8'h12, 8'h08);
		conv(m);
		rchk(8'h10, 8'hFE);
		i_host.wr(8'h10, 8'h55);
		rchk(8'h10, 8'hFE);
		i_host.wr(8'h20, 8'h5A);
		rchk(8'h20, 8'h00);
		i_host.wr(8'h12, 8'h02);
		conv({32'h0000_0000, 16'h0900, 16'h0000});
		rchk(8'h10, 8'h7F);
		rchk(8'h11, 8'hF0);
		i_host.wr(8'h12, 8'h00);
		conv(m);
		rchk(8'h10, 8'h7F);
	endtask
	// stalled write: dropped when the timeout is on, lands when it is off
	task automatic t_tmo();
		for (int k = 0; k < 2; k++) begin
			i_host.wr(8'h13, 8'(k << 5) | 8'h10);
			i_host.start();
			i_host.tx(8'h38);
			i_host.tx(8'h12);
			i_host.w(300);
			i_host.tx(8'h05);
			i_host.stop();
			rchk(8'h12, (k == 1) ? 8'h05 : 8'h0F);
			i_host.wr(8'h12, 8'h0F);
		end
		chk({7'h00, nak}, 8'h01);
	endtask
	task automatic t_por();
		i_host.wr(8'h14, 8'hA5);
		chk(ideal, 8'hA5);
		i_host.wr(8'h13, 8'h40);
		chk(ideal, 8'h18);
		chk(outs, 8'h92);
		rchk(8'h13, 8'h10);
		rchk(8'h12, 8'h0F);
		rchk(8'h44, 8'h00);
		rchk(8'h10, 8'h00);
	endtask
	task automatic summarize();
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		t_reset();
		t_ctrl();
		t_hot();
		t_por();
		chk({7'h00, nak}, 8'h00);
		t_tmo();
		summarize();
	end
	initial begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		summarize();
	end
endmodule // test_tmr_top
`default_nettype wire
